// ==== src/node_fault_defs.svh ====
// constants for the node fault table window: bit positions, codes, timing
`ifndef NODE_FAULT_DEFS_SVH
`define NODE_FAULT_DEFS_SVH

// network size and entry fields
`define NODE_COUNT 64
`define NODE_IDX_W 6
`define CODE_W 8
`define DATA_W 16

// bit positions inside the 8-bit command group
`define CMD_STOP_BIT 0
`define CMD_EXPL_BIT 1
`define CMD_FIRST_BIT 2
`define CMD_NEXT_BIT 3
`define CMD_CLEAR_BIT 4

// bit positions inside the 16-bit module status word
`define STAT_OFFLINE_BIT 0
`define STAT_STOPPED_BIT 1
`define STAT_EXPL_LSB 2
`define STAT_EXPL_W 10

// fault code values
`define CODE_NONE 8'h00
`define CODE_POLL_TIME 8'h01
`define CODE_SIZE_FIRST 8'h12
`define CODE_SIZE_LAST 8'h14

// reset values
`define VIEW_RESET 16'h0000
`define STATUS_RESET 16'h0000

// timing: one millisecond in picoseconds, clock period in picoseconds
`define MS_TIME_PS 32'h3B9ACA00
`define CLK_PERIOD_PS 32'h00000FA0
`define MS_CYCLES (`MS_TIME_PS / `CLK_PERIOD_PS)

`endif

// ==== src/node_fault_pkg.sv ====
// types shared by the node fault table window
package node_fault_pkg;

  // fault report from the protocol engine
  typedef struct packed {
    logic valid;
    logic [5:0] node;
    logic [7:0] code;
    logic [7:0] size_reported;
    logic [7:0] size_expected;
  } fault_evt_t;

  // poll command sent or poll response received for one node
  typedef struct packed {
    logic valid;
    logic [5:0] node;
  } poll_evt_t;

  // explicit message request handed to the protocol engine
  typedef struct packed {
    logic send;
    logic [15:0] tx_first;
    logic [15:0] tx_count;
    logic [15:0] rx_first;
    logic [15:0] rx_size;
  } explicit_req_t;

endpackage

// ==== src/node_fault_table_window.sv ====
// node fault table with single-entry display window and host bit/word map
`timescale 1ns/1ps
`include "node_fault_defs.svh"

module node_fault_table_window #(
  parameter int MS_CYCLES = `MS_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic [7:0] stop_scanning_and_commands_in,
  input wire logic [15:0] tx_buffer_first_word_in,
  input wire logic [15:0] tx_buffer_byte_count_in,
  input wire logic [15:0] rx_buffer_first_word_in,
  input wire logic [15:0] rx_buffer_byte_size_in,
  input wire logic [15:0] strobe_bits_nodes_0_15_in,
  input wire logic [15:0] strobe_bits_nodes_16_31_in,
  input wire logic [15:0] strobe_bits_nodes_32_47_in,
  input wire logic [15:0] strobe_bits_nodes_48_63_in,
  input wire logic [`NODE_COUNT-1:0] node_configured_in,
  input wire logic [`NODE_COUNT-1:0] node_established_in,
  input wire node_fault_pkg::fault_evt_t fault_evt_in,
  input wire node_fault_pkg::poll_evt_t poll_sent_in,
  input wire node_fault_pkg::poll_evt_t poll_rsp_in,
  input wire logic [`STAT_EXPL_W-1:0] explicit_status_in,
  output logic scan_enable_out,
  output logic [`NODE_COUNT-1:0] strobe_cmd_out,
  output logic [`NODE_COUNT-1:0] poll_pending_out,
  output node_fault_pkg::explicit_req_t explicit_req_out,
  output logic [15:0] module_status_bits_out,
  output logic [15:0] online_nodes_0_15_out,
  output logic [15:0] online_nodes_16_31_out,
  output logic [15:0] online_nodes_32_47_out,
  output logic [15:0] online_nodes_48_63_out,
  output logic [15:0] fault_view_addr_code_out,
  output logic [15:0] fault_view_data_out
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------

  // circular search for the first set bit at or after start;
  // returns start itself when the mask is empty
  function automatic logic [5:0] find_from(input logic [63:0] m,
                                           input logic [5:0] s);
    logic [5:0] r;
    logic f;
    logic [5:0] j;
    r = s;
    f = 1'b0;
    for (int k = 0; k < 64; k++) begin
      j = s + 6'(k);
      if (!f && m[j]) begin
        r = j;
        f = 1'b1;
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // command decode and edge detection
  // ---------------------------------------------------------------

  logic stop_scanning_cmd;
  logic send_explicit_cmd;
  logic show_first_fault_cmd;
  logic show_next_fault_cmd;
  logic clear_faults_cmd;
  logic [2:0] cmd_prev_r;
  logic [2:0] cmd_prev_nxt;
  logic first_pulse;
  logic next_pulse;
  logic clr_pulse;

  // named bits of the command group
  assign stop_scanning_cmd = stop_scanning_and_commands_in[`CMD_STOP_BIT];
  assign send_explicit_cmd = stop_scanning_and_commands_in[`CMD_EXPL_BIT];
  assign show_first_fault_cmd =
    stop_scanning_and_commands_in[`CMD_FIRST_BIT];
  assign show_next_fault_cmd =
    stop_scanning_and_commands_in[`CMD_NEXT_BIT];
  assign clear_faults_cmd = stop_scanning_and_commands_in[`CMD_CLEAR_BIT];

  // a held bit must not keep stepping the window, so act on rise only
  always_comb begin
    cmd_prev_nxt = {clear_faults_cmd, show_next_fault_cmd,
                    show_first_fault_cmd};
    first_pulse = show_first_fault_cmd && !cmd_prev_r[0];
    next_pulse = show_next_fault_cmd && !cmd_prev_r[1];
    clr_pulse = clear_faults_cmd && !cmd_prev_r[2];
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cmd_prev_r <= 3'h0;
    end else begin
      cmd_prev_r <= cmd_prev_nxt;
    end
  end

  // ---------------------------------------------------------------
  // millisecond time base and poll bookkeeping
  // ---------------------------------------------------------------

  logic [31:0] ms_div_r;
  logic [31:0] ms_div_nxt;
  logic [15:0] ms_now_r;
  logic [15:0] ms_now_nxt;
  logic [15:0] stamp_r [`NODE_COUNT];
  logic [15:0] stamp_nxt [`NODE_COUNT];
  logic [`NODE_COUNT-1:0] seen_r;
  logic [`NODE_COUNT-1:0] seen_nxt;
  logic [`NODE_COUNT-1:0] pend_r;
  logic [`NODE_COUNT-1:0] pend_nxt;
  logic [`NODE_COUNT-1:0] sent_mask;
  logic [`NODE_COUNT-1:0] rsp_mask;
  logic poll_ok;
  logic [15:0] interval_ms;

  // stamps wrap at 16 bits; intervals above 65 s alias, which the
  // 16-bit display word cannot show anyway
  always_comb begin
    poll_ok = poll_sent_in.valid && !stop_scanning_cmd;
    sent_mask = {`NODE_COUNT{poll_ok}} &
                (64'h1 << poll_sent_in.node);
    rsp_mask = {`NODE_COUNT{poll_rsp_in.valid}} &
               (64'h1 << poll_rsp_in.node);
    interval_ms = ms_now_r - stamp_r[poll_sent_in.node];
    ms_div_nxt = ms_div_r + 32'h1;
    ms_now_nxt = ms_now_r;
    if (ms_div_r == 32'(MS_CYCLES - 1)) begin
      ms_div_nxt = 32'h0;
      ms_now_nxt = ms_now_r + 16'h1;
    end
    stamp_nxt = stamp_r;
    if (poll_ok) begin
      stamp_nxt[poll_sent_in.node] = ms_now_r;
    end
    seen_nxt = stop_scanning_cmd ? 64'h0 : (seen_r | sent_mask);
    // a new command may go out while older nodes still owe answers
    pend_nxt = (pend_r & ~rsp_mask) | sent_mask;
    if (stop_scanning_cmd) begin
      pend_nxt = 64'h0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ms_div_r <= 32'h0;
      ms_now_r <= 16'h0;
      seen_r <= 64'h0;
      pend_r <= 64'h0;
      for (int i = 0; i < `NODE_COUNT; i++) begin
        stamp_r[i] <= 16'h0;
      end
    end else begin
      ms_div_r <= ms_div_nxt;
      ms_now_r <= ms_now_nxt;
      seen_r <= seen_nxt;
      pend_r <= pend_nxt;
      stamp_r <= stamp_nxt;
    end
  end

  // ---------------------------------------------------------------
  // fault table
  // ---------------------------------------------------------------

  logic [7:0] code_r [`NODE_COUNT];
  logic [7:0] code_nxt [`NODE_COUNT];
  logic [15:0] data_r [`NODE_COUNT];
  logic [15:0] data_nxt [`NODE_COUNT];
  logic [`NODE_COUNT-1:0] has_fault;
  logic evt_size;

  // clear first, then the new report, so a report in the clear
  // cycle survives; a lower code never displaces a higher one
  always_comb begin
    evt_size = (fault_evt_in.code >= `CODE_SIZE_FIRST) &&
               (fault_evt_in.code <= `CODE_SIZE_LAST);
    for (int i = 0; i < `NODE_COUNT; i++) begin
      code_nxt[i] = clr_pulse ? `CODE_NONE : code_r[i];
      data_nxt[i] = clr_pulse ? 16'h0 : data_r[i];
      if (fault_evt_in.valid && fault_evt_in.node == 6'(i) &&
          fault_evt_in.code > code_nxt[i]) begin
        code_nxt[i] = fault_evt_in.code;
        // size faults carry reported and expected; others no data
        data_nxt[i] = evt_size ?
          {fault_evt_in.size_reported,
           fault_evt_in.size_expected} : 16'h0;
      end
      if (poll_ok && seen_r[i] && poll_sent_in.node == 6'(i) &&
          code_nxt[i] <= `CODE_POLL_TIME) begin
        code_nxt[i] = `CODE_POLL_TIME;
        data_nxt[i] = interval_ms;
      end
      has_fault[i] = code_r[i] != `CODE_NONE;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < `NODE_COUNT; i++) begin
        code_r[i] <= `CODE_NONE;
        data_r[i] <= 16'h0;
      end
    end else begin
      code_r <= code_nxt;
      data_r <= data_nxt;
    end
  end

  // ---------------------------------------------------------------
  // display window
  // ---------------------------------------------------------------

  logic [5:0] sel_r;
  logic [5:0] sel_nxt;
  logic [5:0] first_idx;
  logic [5:0] next_idx;
  logic [15:0] view_ac_nxt;
  logic [15:0] view_data_nxt;

  // selection uses the table as it stood before this edge; the host
  // keeps the three commands exclusive, so first wins if not
  always_comb begin
    first_idx = find_from(has_fault, 6'h00);
    next_idx = find_from(has_fault, sel_r + 6'h01);
    sel_nxt = sel_r;
    if (first_pulse) begin
      sel_nxt = first_idx;
    end else if (next_pulse) begin
      sel_nxt = next_idx;
    end
    view_ac_nxt = {code_nxt[sel_nxt], 2'b00, sel_nxt};
    view_data_nxt = data_nxt[sel_nxt];
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sel_r <= 6'h00;
      fault_view_addr_code_out <= `VIEW_RESET;
      fault_view_data_out <= `VIEW_RESET;
    end else begin
      sel_r <= sel_nxt;
      fault_view_addr_code_out <= view_ac_nxt;
      fault_view_data_out <= view_data_nxt;
    end
  end

  // ---------------------------------------------------------------
  // online, strobe, status and explicit words
  // ---------------------------------------------------------------

  logic [`NODE_COUNT-1:0] online_r;
  logic [`NODE_COUNT-1:0] online_nxt;
  logic [`NODE_COUNT-1:0] strobe_nxt;
  logic [15:0] status_nxt;
  node_fault_pkg::explicit_req_t expl_nxt;

  // online needs an established link that has answered a poll
  always_comb begin
    online_nxt = node_established_in & (online_r | rsp_mask);
    strobe_nxt = {strobe_bits_nodes_48_63_in, strobe_bits_nodes_32_47_in,
                  strobe_bits_nodes_16_31_in,
                  strobe_bits_nodes_0_15_in};
    if (stop_scanning_cmd) begin
      online_nxt = 64'h0;
      strobe_nxt = 64'h0;
    end
    status_nxt = `STATUS_RESET;
    status_nxt[`STAT_OFFLINE_BIT] = |(node_configured_in & ~online_r);
    status_nxt[`STAT_STOPPED_BIT] = stop_scanning_cmd;
    status_nxt[`STAT_EXPL_LSB +: `STAT_EXPL_W] = explicit_status_in;
    expl_nxt.send = send_explicit_cmd && !stop_scanning_cmd;
    expl_nxt.tx_first = tx_buffer_first_word_in;
    expl_nxt.tx_count = tx_buffer_byte_count_in;
    expl_nxt.rx_first = rx_buffer_first_word_in;
    expl_nxt.rx_size = rx_buffer_byte_size_in;
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      online_r <= 64'h0;
      strobe_cmd_out <= 64'h0;
      module_status_bits_out <= `STATUS_RESET;
      explicit_req_out <= '0;
      scan_enable_out <= 1'b0;
    end else begin
      online_r <= online_nxt;
      strobe_cmd_out <= strobe_nxt;
      module_status_bits_out <= status_nxt;
      explicit_req_out <= expl_nxt;
      scan_enable_out <= !stop_scanning_cmd;
    end
  end

  // node 0 in bit 0 of the first word, upward from there
  assign online_nodes_0_15_out = online_r[15:0];
  assign online_nodes_16_31_out = online_r[31:16];
  assign online_nodes_32_47_out = online_r[47:32];
  assign online_nodes_48_63_out = online_r[63:48];
  assign poll_pending_out = pend_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------

  logic [5:0] watch_node_r;
  logic [7:0] watch_code_r;
  logic watch_low_r;
  logic watch_up_r;
  logic table_empty;

  // snapshot of each report so the table outcome can be checked
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      watch_node_r <= 6'h00;
      watch_code_r <= 8'h00;
      watch_low_r <= 1'b0;
      watch_up_r <= 1'b0;
    end else begin
      watch_node_r <= fault_evt_in.node;
      watch_code_r <= fault_evt_in.valid ?
        code_r[fault_evt_in.node] : fault_evt_in.code;
      watch_low_r <= fault_evt_in.valid && !clr_pulse &&
        fault_evt_in.code <= code_r[fault_evt_in.node];
      watch_up_r <= fault_evt_in.valid &&
        fault_evt_in.code > code_r[fault_evt_in.node];
    end
  end

  always_comb begin
    table_empty = ~|has_fault;
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_first_rise;
    !show_first_fault_cmd ##1 show_first_fault_cmd;
  endsequence

  sequence s_quiet_clear;
    clr_pulse && !fault_evt_in.valid && !poll_sent_in.valid;
  endsequence

  property p_once;
    s_first_rise ##1 show_first_fault_cmd |-> !first_pulse;
  endproperty
  a_once: assert property (p_once)
    else $error("held show-first acted twice");

  property p_clear;
    s_quiet_clear |=> table_empty;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear left a table entry");

  property p_first;
    first_pulse |=> sel_r == $past(first_idx);
  endproperty
  a_first: assert property (p_first)
    else $error("show-first picked wrong node");

  property p_next;
    next_pulse && !first_pulse |=> sel_r == $past(next_idx);
  endproperty
  a_next: assert property (p_next)
    else $error("show-next picked wrong node");

  property p_view;
    ##1 fault_view_addr_code_out == {code_r[sel_r], 2'b00, sel_r} &&
        fault_view_data_out == data_r[sel_r];
  endproperty
  a_view: assert property (p_view)
    else $error("window does not show selected entry");

  property p_keep_high;
    watch_low_r |-> code_r[watch_node_r] >= watch_code_r;
  endproperty
  a_keep_high: assert property (p_keep_high)
    else $error("lower code displaced a higher one");

  property p_raise;
    fault_evt_in.valid && fault_evt_in.code > code_r[fault_evt_in.node]
      |=> code_r[watch_node_r] == $past(fault_evt_in.code) && watch_up_r;
  endproperty
  a_raise: assert property (p_raise)
    else $error("higher code was not stored");

  property p_stop;
    stop_scanning_cmd [*2] |-> !scan_enable_out && online_r == 64'h0 &&
      module_status_bits_out[`STAT_STOPPED_BIT] && pend_r == 64'h0;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop did not release all nodes");

  property p_online;
    ##1 (online_r & ~$past(node_established_in)) == 64'h0;
  endproperty
  a_online: assert property (p_online)
    else $error("node online without established link");

endmodule

// ==== testbench/engine_model.sv ====
// far-side protocol engine model: fault reports and poll traffic
`timescale 1ns/1ps
module engine_model (
  input wire logic clk_in,
  output node_fault_pkg::fault_evt_t fault_evt_out,
  output node_fault_pkg::poll_evt_t poll_sent_out,
  output node_fault_pkg::poll_evt_t poll_rsp_out
);
  // ----------------------------------------
  // idle levels
  // ----------------------------------------
  initial begin
    fault_evt_out = '0;
    poll_sent_out = '0;
    poll_rsp_out = '0;
  end

  // ----------------------------------------
  // one-cycle events, launched off the sampling edge
  // ----------------------------------------
  // size data rides along with every code; device must drop it if unused
  task automatic report(input logic [5:0] n, input logic [7:0] c,
                        input logic [15:0] d);
    fault_evt_out = '{1'b1, n, c, d[15:8], d[7:0]};
    @(negedge clk_in);
    fault_evt_out = '0;
    // idle cycle so a following call never drives in the same step
    @(negedge clk_in);
  endtask

  // poll command sent; several may stay unanswered at once
  task automatic send(input logic [5:0] n);
    poll_sent_out = '{1'b1, n};
    @(negedge clk_in);
    poll_sent_out = '0;
    @(negedge clk_in);
  endtask

  task automatic resp(input logic [5:0] n);
    poll_rsp_out = '{1'b1, n};
    @(negedge clk_in);
    poll_rsp_out = '0;
    @(negedge clk_in);
  endtask
endmodule

// ==== testbench/tb_top.sv ====
// self-checking bench for the node fault table window
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk;
  logic arst_n;
  logic [7:0] cmd;
  logic [15:0] tx_f, tx_c, rx_f, rx_s;
  logic [15:0] sw [4];
  logic [63:0] cfg, est;
  logic [9:0] expl;
  node_fault_pkg::fault_evt_t fev;
  node_fault_pkg::poll_evt_t psent, prsp;
  node_fault_pkg::explicit_req_t xreq;
  logic scan_en;
  logic [63:0] strobe, pend;
  logic [15:0] stat, on0, on1, on2, on3, vac, vd;
  int fail_count;
  int compares;

  node_fault_table_window #(.MS_CYCLES(4)) dut (
    .sys_clk_in(clk),
    .arst_n_in(arst_n),
    .stop_scanning_and_commands_in(cmd),
    .tx_buffer_first_word_in(tx_f),
    .tx_buffer_byte_count_in(tx_c),
    .rx_buffer_first_word_in(rx_f),
    .rx_buffer_byte_size_in(rx_s),
    .strobe_bits_nodes_0_15_in(sw[0]),
    .strobe_bits_nodes_16_31_in(sw[1]),
    .strobe_bits_nodes_32_47_in(sw[2]),
    .strobe_bits_nodes_48_63_in(sw[3]),
    .node_configured_in(cfg),
    .node_established_in(est),
    .fault_evt_in(fev),
    .poll_sent_in(psent),
    .poll_rsp_in(prsp),
    .explicit_status_in(expl),
    .scan_enable_out(scan_en),
    .strobe_cmd_out(strobe),
    .poll_pending_out(pend),
    .explicit_req_out(xreq),
    .module_status_bits_out(stat),
    .online_nodes_0_15_out(on0),
    .online_nodes_16_31_out(on1),
    .online_nodes_32_47_out(on2),
    .online_nodes_48_63_out(on3),
    .fault_view_addr_code_out(vac),
    .fault_view_data_out(vd)
  );

  engine_model eng (
    .clk_in(clk),
    .fault_evt_out(fev),
    .poll_sent_out(psent),
    .poll_rsp_out(prsp)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // one table command at a time, low again before the next rise
  task automatic pulse(input int b);
    cmd[b] = 1'b1;
    tick(1);
    cmd[b] = 1'b0;
    tick(1);
  endtask

  task automatic view(input logic [15:0] ac, input logic [15:0] d);
    chk(vac, ac);
    chk(vd, d);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    view(16'h0000, 16'h0000);
    chk(scan_en, 1'b1);
    tx_f = 16'h1234;
    rx_s = 16'hBEEF;
    sw[0] = 16'h8001;
    sw[1] = 16'h0F00;
    sw[2] = 16'h3C00;
    sw[3] = 16'hA5C3;
    tx_c = 16'h5A5A;
    rx_f = 16'h00C3;
    cmd[1] = 1'b1;
    cfg[3] = 1'b1;
    expl = 10'h2A5;
    tick(2);
    chk({xreq.tx_first, xreq.rx_size}, 32'h1234BEEF);
    chk({xreq.send, xreq.tx_count, xreq.rx_first}, 33'h1_5A5A_00C3);
    chk(strobe, 64'hA5C3_3C00_0F00_8001);
    chk(stat, {4'h0, 10'h2A5, 1'b0, 1'b1});
    $display("test reset done");
  endtask

  // codes 2 to 20 in turn on one node; lower code never displaces
  task automatic t_codes;
    logic [15:0] d;
    pulse(4);
    eng.report(6'd7, 8'h02, 16'h0000);
    pulse(2);
    view(16'h0207, 16'h0000);
    for (int c = 3; c <= 20; c++) begin
      d = (c >= 18) ? {8'(c), 8'(c + 1)} : 16'h0000;
      eng.report(6'd7, 8'(c), {8'(c), 8'(c + 1)});
      tick(1);
      view({8'(c), 8'h07}, d);
    end
    eng.report(6'd7, 8'h06, 16'h0000);
    tick(1);
    view(16'h1407, 16'h1415);
    $display("test codes done");
  endtask

  task automatic t_next;
    pulse(4);
    eng.report(6'd9, 8'h03, 16'h0000);
    eng.report(6'd40, 8'h0F, 16'h0000);
    eng.report(6'd5, 8'h06, 16'h0000);
    pulse(2);
    view(16'h0605, 16'h0000);
    pulse(3);
    view(16'h0309, 16'h0000);
    pulse(3);
    view(16'h0F28, 16'h0000);
    pulse(3);
    view(16'h0605, 16'h0000);
    cmd[3] = 1'b1;
    tick(4);
    cmd[3] = 1'b0;
    tick(1);
    view(16'h0309, 16'h0000);
    pulse(4);
    view(16'h0009, 16'h0000);
    pulse(2);
    view(16'h0000, 16'h0000);
    $display("test next done");
  endtask

  // overlapped polls, online words, then a 12-cycle (3 ms) interval;
  // each engine call takes two cycles, so sends land 12 edges apart
  task automatic t_poll;
    est[3] = 1'b1;
    est[50] = 1'b1;
    cfg[50] = 1'b1;
    eng.send(6'd3);
    eng.send(6'd50);
    tick(1);
    chk(pend, 64'h0004_0000_0000_0008);
    eng.resp(6'd3);
    eng.resp(6'd50);
    tick(1);
    chk(on0, 16'h0008);
    chk({on3, on2, on1}, 48'h0004_0000_0000);
    chk(pend, 64'h0);
    chk(stat[0], 1'b0);
    tick(2);
    eng.send(6'd3);
    pulse(2);
    view(16'h0103, 16'h0003);
    $display("test poll done");
  endtask

  task automatic t_stop;
    cmd[0] = 1'b1;
    tick(2);
    eng.send(6'd7);
    tick(1);
    chk(scan_en, 1'b0);
    chk(stat[1], 1'b1);
    chk(strobe, 64'h0);
    chk({on3, on2, on1, on0}, 64'h0);
    chk(pend, 64'h0);
    chk(xreq.send, 1'b0);
    cmd[0] = 1'b0;
    tick(2);
    chk(scan_en, 1'b1);
    chk(stat[1], 1'b0);
    chk(xreq.send, 1'b1);
    chk(strobe, 64'hA5C3_3C00_0F00_8001);
    $display("test stop done");
  endtask

  // ----------------------------------------
  // clock, main sequence, watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    arst_n = 1'b0;
    cmd = 8'h00;
    tx_f = 16'h0000;
    tx_c = 16'h0042;
    rx_f = 16'h0100;
    rx_s = 16'h0000;
    sw = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
    cfg = 64'h0;
    est = 64'h0;
    expl = 10'h000;
    fail_count = 0;
    compares = 0;
    tick(5);
    arst_n = 1'b1;
    tick(1);
    t_reset;
    t_codes;
    t_next;
    t_poll;
    t_stop;
    end_sim;
  end

  // whole run is about 120 cycles; this is far beyond it
  initial begin
    repeat (4000) @(posedge clk);
    fail_count++;
    end_sim;
  end
endmodule
